// ==== design/asgc_pkg.sv ====
// shared constants and types of the sequence and general control bank
package asgc_pkg;
    // pointer byte fields
    localparam logic [3:0] MODE_CFG      = 4'h0;  // config write mode
    localparam logic [3:0] MODE_RDBK     = 4'h7;  // register readback mode
    localparam logic [3:0] SEL_NOP       = 4'h0;  // no register
    localparam logic [3:0] SEL_SEQ       = 4'h2;  // sequence select code
    localparam logic [3:0] SEL_CTRL      = 4'h3;  // general control code
    // reset values
    localparam logic [15:0] SEQ_RST      = 16'h0000;
    localparam logic [15:0] CTRL_RST     = 16'h0000;
    // writable bits, everything else reads zero
    localparam logic [15:0] SEQ_MASK     = 16'h03ff;
    localparam logic [15:0] CTRL_MASK    = 16'h03f0;
    // sequence register fields
    localparam int SEQ_LOOP_BIT          = 9;
    localparam int SEQ_TEMP_BIT          = 8;
    localparam int SEQ_CH_LSB            = 0;
    // control register fields
    localparam int CTRL_PRECH_BIT        = 9;
    localparam int CTRL_BUF_EN_BIT       = 8;
    localparam int CTRL_LOCK_BIT         = 7;
    localparam int CTRL_BCAST_BIT        = 6;
    localparam int CTRL_IN_RANGE_BIT     = 5;
    localparam int CTRL_OUT_RANGE_BIT    = 4;
    // widths
    localparam int NUM_CH                = 8;
    localparam int DAC_W                 = 12;

    // byte parser states
    typedef enum logic [1:0] {
        ST_PTR,
        ST_HI,
        ST_LO,
        ST_SKIP
    } asgc_state_e;

    // dac load request towards the dac channels
    typedef struct packed {
        logic [NUM_CH-1:0] mask;   // channels to load
        logic [DAC_W-1:0]  data;   // code to load
    } asgc_dac_load_s;
endpackage

// ==== design/asgc_regs.sv ====
// sequence select and general control registers behind the pointer byte
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - sequence register resets to all zeros
// - bit 9 turns sequence repetition on
// - bit 8 adds temperature result to sequence
// - bits 7..0 each include their channel
// - control register resets to all zeros
// - precharge bit 0: enabled buffer always powered
// - precharge bit 1: buffer powered only converting
// - control bit 8 enables input buffer
// - lock bit refuses pin configuration writes
// - broadcast off: dac write loads addressed channel
// - broadcast on: load every dac-configured channel
// - input range bit picks single or double span
// - output range bit picks single or double span
// - pointer 0x7 plus select reads register back
module asgc_regs #(
    parameter int NUM_CH = 8,                        // analog channels
    parameter int DAC_W  = 12                        // dac code width
) (
    input  wire logic                     core_clk,      // core clock, 25 MHz
    input  wire logic                     rst,           // synchronous reset
    input  wire logic                     frm_start,     // start of serial frame
    input  wire logic                     byte_valid,    // received byte strobe
    input  wire logic [7:0]               byte_data,     // received byte
    input  wire logic                     rd_req,        // host wants next byte
    input  wire logic                     conv_busy,     // conversion running
    input  wire logic                     pincfg_wr_req, // pin config write asked
    input  wire logic                     dac_wr_valid,  // dac data write strobe
    input  wire logic [2:0]               dac_wr_chan,   // channel address
    input  wire logic [DAC_W-1:0]         dac_wr_data,   // dac code
    input  wire logic [NUM_CH-1:0]        dac_cfg_mask,  // channels set as dac
    output logic [7:0]                    rd_data,       // readback byte
    output logic                          rd_valid,      // readback byte strobe
    output logic [NUM_CH-1:0]             seq_chan,      // channels in sequence
    output logic                          seq_temp,      // temperature included
    output logic                          sequence_loop_enable, // repeat sequence
    output logic                          buf_power,     // input buffer powered
    output logic                          cfg_lock,      // pin config locked
    output logic                          pincfg_wr_en,  // pin config write go
    output logic                          dac_load_valid, // dac load strobe
    output asgc_pkg::asgc_dac_load_s      dac_load,      // dac load mask, data
    output logic                          in_range_2x,   // input span doubled
    output logic                          out_range_2x   // output span doubled
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    // the field layout is fixed at eight channels and twelve-bit codes
    if (NUM_CH != asgc_pkg::NUM_CH || DAC_W != asgc_pkg::DAC_W) begin : g_bad
        $error("asgc_regs: unsupported channel count or dac width");
    end

    ////////////////////////////////////////////////////////////////////////////
    // state

    asgc_pkg::asgc_state_e    st_ff;         // byte parser state
    logic [3:0]               wsel_ff;       // register chosen for writing
    logic [7:0]               hi_ff;         // high data byte held
    logic [3:0]               rsel_ff;       // register chosen for readback
    logic                     rd_half_ff;    // next read byte is the low one
    logic [15:0]              seq_ff;        // sequence select register
    logic [15:0]              ctrl_ff;       // general control register
    logic [7:0]               rd_data_ff;    // readback byte
    logic                     rd_valid_ff;   // readback byte strobe
    logic                     buf_power_ff;  // buffer power request
    logic                     pincfg_en_ff;  // pin config write granted
    logic                     dac_vld_ff;    // dac load strobe
    asgc_pkg::asgc_dac_load_s dac_load_ff;   // dac load request
    logic                     commit;        // second data byte arrives
    logic [15:0]              wword;         // full word being written
    logic                     rd_take;       // read request served
    logic [15:0]              rd_word;       // register picked for readback
    logic                     byte_take;     // byte handled by parser

    // register contents for a select code; unknown codes read zero
    function automatic logic [15:0] reg_by_sel(
        input logic [3:0]  sel,
        input logic [15:0] seq,
        input logic [15:0] ctrl
    );
        logic [15:0] r;
        r = 16'h0000;
        if (sel == asgc_pkg::SEL_SEQ) begin
            r = seq;
        end else if (sel == asgc_pkg::SEL_CTRL) begin
            r = ctrl;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // byte parser

    // a new frame wins over a byte in the same cycle
    assign byte_take = byte_valid && !frm_start;
    assign commit    = byte_take && (st_ff == asgc_pkg::ST_LO);
    assign wword     = {hi_ff, byte_data};

    // first byte is the pointer, then high and low data bytes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_ff   <= asgc_pkg::ST_PTR;
            wsel_ff <= asgc_pkg::SEL_NOP;
            hi_ff   <= 8'h00;
        end else if (frm_start) begin
            st_ff <= asgc_pkg::ST_PTR;
        end else if (byte_valid) begin
            case (st_ff)
                asgc_pkg::ST_PTR: begin
                    // only the two codes of this bank open a write
                    if (byte_data[7:4] == asgc_pkg::MODE_CFG &&
                        (byte_data[3:0] == asgc_pkg::SEL_SEQ ||
                         byte_data[3:0] == asgc_pkg::SEL_CTRL)) begin
                        wsel_ff <= byte_data[3:0];
                        st_ff   <= asgc_pkg::ST_HI;
                    end else begin
                        st_ff <= asgc_pkg::ST_SKIP;
                    end
                end
                asgc_pkg::ST_HI: begin
                    hi_ff <= byte_data;
                    st_ff <= asgc_pkg::ST_LO;
                end
                asgc_pkg::ST_LO: begin
                    // extra bytes in the frame are dropped
                    st_ff <= asgc_pkg::ST_SKIP;
                end
                default: begin
                    st_ff <= asgc_pkg::ST_SKIP;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    // sequence register; reserved bits masked away on write
    always_ff @(posedge core_clk) begin
        if (rst) begin
            seq_ff <= asgc_pkg::SEQ_RST;
        end else if (commit && wsel_ff == asgc_pkg::SEL_SEQ) begin
            seq_ff <= wword & asgc_pkg::SEQ_MASK;
        end
    end

    // general control register; bits 3..0 stay zero too
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_ff <= asgc_pkg::CTRL_RST;
        end else if (commit && wsel_ff == asgc_pkg::SEL_CTRL) begin
            ctrl_ff <= wword & asgc_pkg::CTRL_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // readback

    assign rd_take = rd_req && !frm_start;
    assign rd_word = reg_by_sel(rsel_ff, seq_ff, ctrl_ff);

    // readback pointer selects a register, high byte goes out first
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rsel_ff    <= asgc_pkg::SEL_NOP;
            rd_half_ff <= 1'b0;
        end else if (frm_start) begin
            rd_half_ff <= 1'b0;
        end else begin
            if (byte_valid && st_ff == asgc_pkg::ST_PTR &&
                byte_data[7:4] == asgc_pkg::MODE_RDBK) begin
                rsel_ff    <= byte_data[3:0];
                rd_half_ff <= 1'b0;
            end else if (rd_take) begin
                rd_half_ff <= !rd_half_ff;
            end
        end
    end

    // one byte answered the cycle after each request outside a frame-start cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_data_ff  <= 8'h00;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= rd_take;
            if (rd_take) begin
                rd_data_ff <= rd_half_ff ? rd_word[7:0] : rd_word[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // input buffer power

    // precharge-only mode trades settling margin for supply current
    always_ff @(posedge core_clk) begin
        if (rst) begin
            buf_power_ff <= 1'b0;
        end else begin
            buf_power_ff <= ctrl_ff[asgc_pkg::CTRL_BUF_EN_BIT] &&
                            (!ctrl_ff[asgc_pkg::CTRL_PRECH_BIT] ||
                             conv_busy);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin configuration lock

    // a refused write leaves the pin config registers untouched
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pincfg_en_ff <= 1'b0;
        end else begin
            pincfg_en_ff <= pincfg_wr_req && !ctrl_ff[asgc_pkg::CTRL_LOCK_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // dac write steering

    // broadcast uses the dac mask sampled with the write, not a later one
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dac_vld_ff  <= 1'b0;
            dac_load_ff <= '0;
        end else begin
            dac_vld_ff <= dac_wr_valid;
            if (dac_wr_valid) begin
                dac_load_ff.data <= dac_wr_data;
                if (ctrl_ff[asgc_pkg::CTRL_BCAST_BIT]) begin
                    dac_load_ff.mask <= dac_cfg_mask;
                end else begin
                    dac_load_ff.mask <= NUM_CH'(1) << dac_wr_chan;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flip-flops

    assign rd_data              = rd_data_ff;
    assign rd_valid             = rd_valid_ff;
    assign seq_chan             = seq_ff[asgc_pkg::SEQ_CH_LSB +: NUM_CH];
    assign seq_temp             = seq_ff[asgc_pkg::SEQ_TEMP_BIT];
    assign sequence_loop_enable = seq_ff[asgc_pkg::SEQ_LOOP_BIT];
    assign buf_power            = buf_power_ff;
    assign cfg_lock             = ctrl_ff[asgc_pkg::CTRL_LOCK_BIT];
    assign pincfg_wr_en         = pincfg_en_ff;
    assign dac_load_valid       = dac_vld_ff;
    assign dac_load             = dac_load_ff;
    assign in_range_2x          = ctrl_ff[asgc_pkg::CTRL_IN_RANGE_BIT];
    assign out_range_2x         = ctrl_ff[asgc_pkg::CTRL_OUT_RANGE_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // pointer byte that opens readback of the sequence register
    sequence s_rdbk_seq;
        byte_take && st_ff == asgc_pkg::ST_PTR && byte_data == 8'h72;
    endsequence

    sequence s_restart; // fresh frame right after the pointer
        frm_start && !byte_valid;
    endsequence

    // first read request after that pointer
    sequence s_first_rd;
        rd_take && !byte_valid;
    endsequence

    a_seq_reset_zero: assert property (
        @(posedge core_clk) disable iff (1'b0)
        rst |=> seq_ff == 16'h0000 && !sequence_loop_enable)
        else $error("sequence register not zero after reset");

    a_ctrl_reset_zero: assert property (
        @(posedge core_clk) disable iff (1'b0)
        rst |=> ctrl_ff == 16'h0000 && !in_range_2x && !cfg_lock)
        else $error("control register not zero after reset");

    a_seq_write_bits: assert property (
        commit && wsel_ff == asgc_pkg::SEL_SEQ |=>
        sequence_loop_enable == $past(hi_ff[1]) && seq_temp == $past(hi_ff[0]) &&
        seq_chan == $past(byte_data) && seq_ff[15:10] == 6'h00)
        else $error("sequence write did not land");

    a_ctrl_range_bits: assert property (
        commit && wsel_ff == asgc_pkg::SEL_CTRL |=>
        in_range_2x == $past(byte_data[5]) && out_range_2x == $past(byte_data[4]) &&
        ctrl_ff[3:0] == 4'h0)
        else $error("range bits misplaced");

    a_buf_always_on: assert property (
        ctrl_ff[8] && !ctrl_ff[9] ##1 ctrl_ff[8] && !ctrl_ff[9] |-> buf_power)
        else $error("enabled buffer not powered");

    a_buf_prech_off: assert property (
        ctrl_ff[9] && !conv_busy |=> !buf_power)
        else $error("precharge buffer powered while idle");

    a_buf_disabled: assert property (
        !ctrl_ff[8] |=> !buf_power)
        else $error("disabled buffer powered");

    a_lock_refuse: assert property (
        pincfg_wr_req |=> pincfg_wr_en == !$past(cfg_lock))
        else $error("pin config lock not honoured");

    a_dac_single: assert property (
        dac_wr_valid && !ctrl_ff[6] |=>
        dac_load_valid && dac_load.mask == NUM_CH'(1) << $past(dac_wr_chan))
        else $error("single dac write mis-steered");

    a_dac_bcast: assert property (
        dac_wr_valid && ctrl_ff[6] |=>
        dac_load.mask == $past(dac_cfg_mask) && dac_load.data == $past(dac_wr_data))
        else $error("broadcast dac write mis-steered");

    a_rdbk_high: assert property (
        s_rdbk_seq ##1 s_restart ##1 s_first_rd |=>
        rd_valid && rd_data == seq_ff[15:8])
        else $error("readback high byte wrong");

endmodule
`default_nettype wire

// ==== bench/asgc_host_model.sv ====
// host side model: frames, pointer bytes and readback requests at byte level
`timescale 1ns/1ns
`default_nettype none
module asgc_host_model (
    input  wire logic       core_clk,   // core clock
    input  wire logic [7:0] rd_data,    // readback byte from the bank
    input  wire logic       rd_valid,   // readback byte strobe
    output logic            frm_start,  // frame start pulse
    output logic            byte_valid, // received byte strobe
    output logic [7:0]      byte_data,  // received byte
    output logic            rd_req      // next readback byte request
);
    // idle bus at time zero
    initial begin
        frm_start  = 1'b0;
        byte_valid = 1'b0;
        byte_data  = 8'h00;
        rd_req     = 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // one-cycle frame start, changed just after the edge
    task automatic frame();
        @(posedge core_clk);
        frm_start <= 1'b1;
        @(posedge core_clk);
        frm_start <= 1'b0;
    endtask

    // pointer byte then high and low byte back to back
    task automatic write_reg(input logic [7:0] ptr, input logic [15:0] val);
        frame();
        byte_valid <= 1'b1;
        byte_data  <= ptr;
        @(posedge core_clk);
        byte_data  <= val[15:8];
        @(posedge core_clk);
        byte_data  <= val[7:0];
        @(posedge core_clk);
        byte_valid <= 1'b0;
        // released line wanders off the last value, no stale data seen
        byte_data  <= ~val[7:0];
    endtask

    // readback pointer, a fresh frame at once, then two back-to-back requests
    task automatic read_reg(input logic [3:0] sel, output logic [15:0] val);
        frame();
        byte_valid <= 1'b1;
        byte_data  <= {4'h7, sel};
        @(posedge core_clk);
        byte_valid <= 1'b0;
        byte_data  <= ~{4'h7, sel};
        frm_start  <= 1'b1;
        @(posedge core_clk);
        frm_start  <= 1'b0;
        rd_req     <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk);
            // the low byte is asked for right behind the high byte
            rd_req <= (i == 0);
            #1;
            // a missing strobe poisons the word so the compare fails
            if (rd_valid !== 1'b1) begin
                val = 16'hxxxx;
            end else begin
                val = {val[7:0], rd_data};
            end
        end
    endtask
endmodule
`default_nettype wire

// ==== bench/test_adc_sequence_and_general_control.sv ====
// self-checking bench of the sequence and general control bank
`timescale 1ns/1ns
`default_nettype none
module test_adc_sequence_and_general_control;
    logic                     core_clk;       // 25 MHz clock
    logic                     rst;            // synchronous reset
    logic                     frm_start;      // from host model
    logic                     byte_valid;     // from host model
    logic [7:0]               byte_data;      // from host model
    logic                     rd_req;         // from host model
    logic                     conv_busy;      // conversion running
    logic                     pincfg_wr_req;  // pin config write request
    logic                     dac_wr_valid;   // dac write strobe
    logic [2:0]               dac_wr_chan;    // dac channel address
    logic [11:0]              dac_wr_data;    // dac code
    logic [7:0]               dac_cfg_mask;   // channels set as dac
    logic [7:0]               rd_data;        // readback byte
    logic                     rd_valid;       // readback strobe
    logic [7:0]               seq_chan;       // sequence channels
    logic                     seq_temp;       // temperature in sequence
    logic                     sequence_loop_enable; // sequence repeats
    logic                     buf_power;      // input buffer powered
    logic                     cfg_lock;       // pin config locked
    logic                     pincfg_wr_en;   // pin config write granted
    logic                     dac_load_valid; // dac load strobe
    asgc_pkg::asgc_dac_load_s dac_load;       // dac load mask and code
    logic                     in_range_2x;    // input span doubled
    logic                     out_range_2x;   // output span doubled
    logic [15:0]              rv;             // word read back
    logic [15:0]              v;              // word under test
    int                       n_mismatch;     // mismatches seen
    int                       tests_run;      // compares made
    logic [15:0] seq_tab [4] = '{16'hffff, 16'h0155, 16'h02aa, 16'h0000}; // sequence words
    logic [15:0] ctl_tab [5] = '{16'hffff, 16'h0120, 16'h0310, 16'h0240, 16'h0000}; // control

    asgc_regs u_dut (
        .core_clk(core_clk), .rst(rst), .frm_start(frm_start), .byte_valid(byte_valid),
        .byte_data(byte_data), .rd_req(rd_req), .conv_busy(conv_busy),
        .pincfg_wr_req(pincfg_wr_req), .dac_wr_valid(dac_wr_valid),
        .dac_wr_chan(dac_wr_chan), .dac_wr_data(dac_wr_data), .dac_cfg_mask(dac_cfg_mask),
        .rd_data(rd_data), .rd_valid(rd_valid), .seq_chan(seq_chan), .seq_temp(seq_temp),
        .sequence_loop_enable(sequence_loop_enable), .buf_power(buf_power),
        .cfg_lock(cfg_lock), .pincfg_wr_en(pincfg_wr_en), .dac_load_valid(dac_load_valid),
        .dac_load(dac_load), .in_range_2x(in_range_2x), .out_range_2x(out_range_2x)
    );

    asgc_host_model u_host (
        .core_clk(core_clk), .rd_data(rd_data), .rd_valid(rd_valid), .frm_start(frm_start),
        .byte_valid(byte_valid), .byte_data(byte_data), .rd_req(rd_req)
    );

    ////////////////////////////////////////////////////////////////
    // clock: 40 ns period
    always #20 core_clk = ~core_clk;

    // single compare point, four-state exact
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic end_sim();
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // watchdog: the tests need well under 3000 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        conv_busy = 1'b0;
        pincfg_wr_req = 1'b0;
        dac_wr_valid = 1'b0;
        dac_wr_chan = 3'h0;
        dac_wr_data = 12'h000;
        dac_cfg_mask = 8'h5a;
        n_mismatch = 0;
        tests_run = 0;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        u_host.read_reg(4'h2, rv);
        check(rv, 16'h0000);
        u_host.read_reg(4'h3, rv);
        check(rv, 16'h0000);
        // sequence words: fields and readback, reserved bits dropped
        for (int i = 0; i < 4; i++) begin
            v = seq_tab[i];
            u_host.write_reg(8'h02, v);
            u_host.read_reg(4'h2, rv);
            check(rv, v & 16'h03ff);
            check(seq_chan, v[7:0]);
            check(seq_temp, v[8]);
            check(sequence_loop_enable, v[9]);
        end
        // control words: ranges, lock gate, buffer power, dac steering
        for (int i = 0; i < 5; i++) begin
            v = ctl_tab[i];
            u_host.write_reg(8'h03, v);
            u_host.read_reg(4'h3, rv);
            check(rv, v & 16'h03f0);
            check(cfg_lock, v[7]);
            check(in_range_2x, v[5]);
            check(out_range_2x, v[4]);
            for (int b = 0; b < 2; b++) begin
                @(posedge core_clk);
                conv_busy <= b[0];
                repeat (2) @(posedge core_clk);
                #1;
                check(buf_power, v[8] & (!v[9] | b[0]));
            end
            @(posedge core_clk);
            pincfg_wr_req <= 1'b1;
            @(posedge core_clk);
            pincfg_wr_req <= 1'b0;
            #1;
            check(pincfg_wr_en, !v[7]);
            @(posedge core_clk);
            dac_wr_valid <= 1'b1;
            dac_wr_chan <= 3'h3;
            dac_wr_data <= 12'habc;
            @(posedge core_clk);
            dac_wr_valid <= 1'b0;
            dac_wr_chan <= 3'h4;
            dac_wr_data <= 12'h543;
            #1;
            check(dac_load_valid, 1'b1);
            check(dac_load, {(v[6] ? 8'h5a : 8'h08), 12'habc});
            @(posedge core_clk);
            #1;
            check(dac_load_valid, 1'b0);
        end
        // foreign pointer leaves the word alone; a nop select reads zero
        u_host.write_reg(8'h02, 16'h0155);
        u_host.write_reg(8'h05, 16'h0000);
        u_host.read_reg(4'h2, rv);
        check(rv, 16'h0155);
        u_host.read_reg(4'h0, rv);
        check(rv, 16'h0000);
        // second reset in mid-run clears both words
        u_host.write_reg(8'h03, 16'h03f0);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        check(cfg_lock, 1'b0);
        u_host.read_reg(4'h2, rv);
        check(rv, 16'h0000);
        u_host.read_reg(4'h3, rv);
        check(rv, 16'h0000);
        end_sim();
    end
endmodule
`default_nettype wire
